// ===== rtl/dcc_ctrl.sv
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module dcc_ctrl
  import dcc_pkg::*;
#(
  parameter int ADDR_W = 32,
  parameter int MUX_W = 12,
  parameter int COL_BITS = 9,
  parameter int RC_UNIT = DCC_RC_UNIT
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic mem_req,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic mem_write,
  output logic mem_ack,
  output logic mem_miss,
  output logic [1:0] row_strobe_n,
  output logic [3:0] column_strobe_n,
  output logic dram_write,
  output logic [MUX_W-1:0] dram_addr,
  output logic sync_row_strobe_n,
  output logic sync_column_strobe_n
);
  import dcc_pkg::*;

  if (ADDR_W < DCC_BA_LSB + DCC_BA_W || MUX_W < COL_BITS ||
      ADDR_W < MUX_W + COL_BITS)
  begin : g_bad_widths
    $error("dcc_ctrl: address widths cannot be served");
  end

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction : merge_bytes

  function automatic logic blk_hit(input logic [31:0] ac,
                                   input logic [31:0] mask,
                                   input logic [ADDR_W-1:0] a);
    logic [DCC_BA_W-1:0] cmp;
    cmp = (a[DCC_BA_LSB +: DCC_BA_W] ^ ac[DCC_BA_LSB +: DCC_BA_W]) &
          ~mask[DCC_BA_LSB +: DCC_BA_W];
    return ac[DCC_EN_BIT] && (cmp == '0);
  endfunction : blk_hit

  ////////////////////////////////////////////////////////////////////////////

  logic [31:0] ctrl_ff;
  logic [31:0] ac0_ff;
  logic [31:0] mask0_ff;
  logic [31:0] ac1_ff;
  logic [31:0] mask1_ff;
  logic aw_hold_ff;
  logic w_hold_ff;
  logic [11:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire have_aw = aw_hold_ff | aw_take;
  wire have_w = w_hold_ff | w_take;
  wire wr_go = have_aw & have_w & ~bvalid_ff;
  wire [11:0] wr_addr = aw_hold_ff ? awaddr_ff : s_axi_awaddr;
  wire [31:0] wr_data = w_hold_ff ? wdata_ff : s_axi_wdata;
  wire [3:0] wr_strb = w_hold_ff ? wstrb_ff : s_axi_wstrb;
  wire wr_ctrl = wr_go && wr_addr == DCC_CTRL_OFF;
  wire wr_ac0 = wr_go && wr_addr == DCC_BLK0_ADDR_OFF;
  wire wr_mask0 = wr_go && wr_addr == DCC_BLK0_MASK_OFF;
  wire wr_ac1 = wr_go && wr_addr == DCC_BLK1_ADDR_OFF;
  wire wr_mask1 = wr_go && wr_addr == DCC_BLK1_MASK_OFF;
  wire wr_known = wr_ctrl | wr_ac0 | wr_mask0 | wr_ac1 | wr_mask1;
  wire [31:0] ctrl_merged = merge_bytes(ctrl_ff, wr_data, wr_strb);
  // The sync bit can be set by software but only reset clears it.
  wire [31:0] nxt_ctrl = {ctrl_merged[31:16],
                          ctrl_merged[DCC_CTRL_SYNC_BIT] |
                          ctrl_ff[DCC_CTRL_SYNC_BIT],
                          ctrl_merged[14:0]};

  assign s_axi_awready = ~aw_hold_ff & ~bvalid_ff;
  assign s_axi_wready = ~w_hold_ff & ~bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
      bvalid_ff <= 1'b0;
      bresp_ff <= DCC_RESP_OKAY;
    end
    else
    begin
      aw_hold_ff <= have_aw & ~wr_go;
      w_hold_ff <= have_w & ~wr_go;
      if (aw_take)
        awaddr_ff <= s_axi_awaddr;
      if (w_take)
      begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_go)
        bresp_ff <= wr_known ? DCC_RESP_OKAY : DCC_RESP_SLVERR;
      bvalid_ff <= wr_go | (bvalid_ff & ~s_axi_bready);
    end
  end

  // Each block has its own mode, held in its own address-and-control register.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_ff <= DCC_CTRL_RESET;
      ac0_ff <= DCC_BLK_ADDR_RESET;
      mask0_ff <= DCC_BLK_MASK_RESET;
      ac1_ff <= DCC_BLK_ADDR_RESET;
      mask1_ff <= DCC_BLK_MASK_RESET;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_ff <= nxt_ctrl;
      if (wr_ac0)
        ac0_ff <= merge_bytes(ac0_ff, wr_data, wr_strb);
      if (wr_mask0)
        mask0_ff <= merge_bytes(mask0_ff, wr_data, wr_strb);
      if (wr_ac1)
        ac1_ff <= merge_bytes(ac1_ff, wr_data, wr_strb);
      if (wr_mask1)
        mask1_ff <= merge_bytes(mask1_ff, wr_data, wr_strb);
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  dcc_state_t state_ff;
  dcc_state_t nxt_state;
  logic [3:0] tmr_ff;
  logic blk_ff;
  logic row_valid_ff;
  logic [ADDR_W-COL_BITS-1:0] open_row_ff;
  logic [1:0] row_n_ff;
  logic [3:0] col_n_ff;
  logic write_ff;
  logic [MUX_W-1:0] addr_ff;
  logic ack_ff;
  logic miss_ff;
  logic busy_ff;
  logic ref_req;
  logic ref_ack;

  wire [31:0] rd_mux =
    (s_axi_araddr == DCC_CTRL_OFF) ? ctrl_ff :
    (s_axi_araddr == DCC_BLK0_ADDR_OFF) ? ac0_ff :
    (s_axi_araddr == DCC_BLK0_MASK_OFF) ? mask0_ff :
    (s_axi_araddr == DCC_BLK1_ADDR_OFF) ? ac1_ff :
    (s_axi_araddr == DCC_BLK1_MASK_OFF) ? mask1_ff :
    {26'h0, ref_req, row_valid_ff, busy_ff, state_ff};
  wire rd_known = s_axi_araddr == DCC_CTRL_OFF ||
                  s_axi_araddr == DCC_BLK0_ADDR_OFF ||
                  s_axi_araddr == DCC_BLK0_MASK_OFF ||
                  s_axi_araddr == DCC_BLK1_ADDR_OFF ||
                  s_axi_araddr == DCC_BLK1_MASK_OFF ||
                  s_axi_araddr == DCC_STATUS_OFF;

  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= DCC_RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid & ~rvalid_ff)
      begin
        rdata_ff <= rd_known ? rd_mux : 32'h0000_0000;
        rresp_ff <= rd_known ? DCC_RESP_OKAY : DCC_RESP_SLVERR;
      end
      rvalid_ff <= (s_axi_arvalid & ~rvalid_ff) | (rvalid_ff & ~s_axi_rready);
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  dcc_refresh #(
    .RC_UNIT(RC_UNIT)
  ) u_refresh (
    .aclk(aclk),
    .aresetn(aresetn),
    .refresh_count(ctrl_ff[DCC_CTRL_RC_LSB +: DCC_RC_W]),
    .ref_ack(ref_ack),
    .ref_req(ref_req)
  );

  // With overlapping blocks block 0 simply wins; software must avoid it.
  wire hit0 = blk_hit(ac0_ff, mask0_ff, mem_addr);
  wire hit1 = blk_hit(ac1_ff, mask1_ff, mem_addr);
  wire any_hit = hit0 | hit1;
  wire sel_blk = ~hit0;
  wire [31:0] sel_ac = sel_blk ? ac1_ff : ac0_ff;
  wire dcc_amode_t sel_mode = dcc_amode_t'(sel_ac[DCC_MODE_LSB +: 2]);
  wire dcc_port_size_t sel_ps = dcc_port_size_t'(sel_ac[DCC_PS_LSB +: 2]);
  // The page is every address bit above the column, more than the MUX_W row bits sent on the pins.
  wire [ADDR_W-COL_BITS-1:0] req_row = mem_addr[ADDR_W-1:COL_BITS];
  wire page_hit = row_valid_ff && blk_ff == sel_blk &&
                  open_row_ff == req_row;
  wire keep_open = sel_mode != DCC_AM_NONPAGE;
  wire no_mux = ctrl_ff[DCC_CTRL_NOMUX_BIT];
  wire sync_mode = ctrl_ff[DCC_CTRL_SYNC_BIT];
  // Column strobes follow port width: narrow ports use the lower lanes.
  wire [3:0] lane_n = (sel_ps == DCC_PS_8) ? 4'hE :
                      (sel_ps == DCC_PS_16) ? 4'hC : 4'h0;
  wire [MUX_W-1:0] row_addr = mem_addr[COL_BITS +: MUX_W];
  wire [MUX_W-1:0] col_addr = no_mux ? mem_addr[MUX_W-1:0] :
                              MUX_W'(mem_addr[COL_BITS-1:0]);
  wire tmr_done = tmr_ff == '0;
  wire start_ok = mem_req & ~mem_ack & ~miss_ff;

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      DCC_ST_IDLE:
      begin
        if (ref_req)
          nxt_state = DCC_ST_REF;
        else if (start_ok & any_hit)
          nxt_state = DCC_ST_ROW;
      end
      DCC_ST_ROW:
        if (tmr_done)
          nxt_state = DCC_ST_COL;
      DCC_ST_COL:
        if (tmr_done)
          nxt_state = keep_open ? DCC_ST_PAGE : DCC_ST_PRE;
      DCC_ST_PAGE:
      begin
        if (ref_req || (start_ok && !page_hit))
          nxt_state = DCC_ST_PRE;
        else if (start_ok & page_hit)
          nxt_state = DCC_ST_COL;
      end
      DCC_ST_PRE:
        if (tmr_done)
          nxt_state = DCC_ST_IDLE;
      DCC_ST_REF:
        if (tmr_done)
          nxt_state = DCC_ST_PRE;
      default:
        nxt_state = DCC_ST_IDLE;
    endcase
  end

  wire enter = nxt_state != state_ff;
  wire go_row = enter && nxt_state == DCC_ST_ROW;
  wire go_col = enter && nxt_state == DCC_ST_COL;
  assign ref_ack = enter && nxt_state == DCC_ST_REF;
  wire col_end = state_ff == DCC_ST_COL && tmr_done;
  wire [3:0] nxt_tmr = go_row ? DCC_RAS_CYC :
                       go_col ? DCC_CAS_CYC :
                       ref_ack ? DCC_REF_CYC :
                       (enter && nxt_state == DCC_ST_PRE) ? DCC_PRE_CYC :
                       tmr_done ? tmr_ff : tmr_ff - 1'b1;

  // The machine drives every DRAM pin; the sync strobes are also gated by the control sync bit.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_ff <= DCC_ST_IDLE;
      tmr_ff <= '0;
      blk_ff <= 1'b0;
      row_valid_ff <= 1'b0;
      open_row_ff <= '0;
      row_n_ff <= 2'h3;
      col_n_ff <= 4'hF;
      write_ff <= 1'b0;
      addr_ff <= '0;
      ack_ff <= 1'b0;
      miss_ff <= 1'b0;
      busy_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      tmr_ff <= nxt_tmr;
      ack_ff <= col_end;
      // A refresh that wins this cycle defers the miss until it is done.
      miss_ff <= start_ok & ~any_hit & ~ref_req & (state_ff == DCC_ST_IDLE);
      busy_ff <= nxt_state != DCC_ST_IDLE;
      if (go_row)
      begin
        blk_ff <= sel_blk;
        open_row_ff <= req_row;
        row_valid_ff <= 1'b1;
        addr_ff <= row_addr;
        row_n_ff <= sel_blk ? 2'h1 : 2'h2;
        write_ff <= mem_write;
      end
      if (go_col)
      begin
        addr_ff <= col_addr;
        col_n_ff <= lane_n;
        write_ff <= mem_write;
      end
      if (col_end)
        col_n_ff <= 4'hF;
      // Every mode, EDO included, raises the column strobes when the column phase ends.
      if (ref_ack)
      begin
        row_n_ff <= 2'h0;
        col_n_ff <= 4'h0;
        row_valid_ff <= 1'b0;
      end
      if (enter && nxt_state == DCC_ST_PRE)
      begin
        row_n_ff <= 2'h3;
        col_n_ff <= 4'hF;
        row_valid_ff <= 1'b0;
      end
    end
  end

  assign mem_ack = ack_ff;
  assign mem_miss = miss_ff;
  assign row_strobe_n = row_n_ff;
  assign column_strobe_n = col_n_ff;
  assign dram_write = write_ff;
  assign dram_addr = addr_ff;
  assign sync_row_strobe_n = ~sync_mode | (&row_n_ff);
  assign sync_column_strobe_n = ~sync_mode | (&col_n_ff);

endmodule : dcc_ctrl

`default_nettype wire

// ===== common/dcc_pkg.sv
package dcc_pkg;

  // Register byte offsets from the module base.
  localparam logic [11:0] DCC_CTRL_OFF = 12'h100;
  localparam logic [11:0] DCC_BLK0_ADDR_OFF = 12'h108;
  localparam logic [11:0] DCC_BLK0_MASK_OFF = 12'h10C;
  localparam logic [11:0] DCC_BLK1_ADDR_OFF = 12'h110;
  localparam logic [11:0] DCC_BLK1_MASK_OFF = 12'h114;
  localparam logic [11:0] DCC_STATUS_OFF = 12'h118;

  // Control register fields.
  localparam int DCC_CTRL_SYNC_BIT = 15;
  localparam int DCC_CTRL_NOMUX_BIT = 13;
  localparam int DCC_CTRL_RC_LSB = 0;
  localparam int DCC_RC_W = 11;
  localparam logic [31:0] DCC_CTRL_RESET = 32'h0000_0000;

  // Block address-and-control fields.
  localparam int DCC_BA_LSB = 18;
  localparam int DCC_BA_W = 14;
  localparam int DCC_PS_LSB = 4;
  localparam int DCC_MODE_LSB = 2;
  localparam int DCC_EN_BIT = 0;
  localparam logic [31:0] DCC_BLK_ADDR_RESET = 32'h0000_0000;
  localparam logic [31:0] DCC_BLK_MASK_RESET = 32'h0000_0000;

  // Refresh interval unit in clock cycles per count.
  localparam int DCC_RC_UNIT = 16;
  localparam int DCC_RC_CNT_W = 16;

  // Access timing in clock cycles.
  localparam logic [3:0] DCC_RAS_CYC = 4'h2;
  localparam logic [3:0] DCC_CAS_CYC = 4'h2;
  localparam logic [3:0] DCC_PRE_CYC = 4'h2;
  localparam logic [3:0] DCC_REF_CYC = 4'h4;

  localparam logic [1:0] DCC_RESP_OKAY = 2'h0;
  localparam logic [1:0] DCC_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0]
  {
    DCC_PS_32 = 2'h0,
    DCC_PS_8 = 2'h1,
    DCC_PS_16 = 2'h2
  } dcc_port_size_t;

  typedef enum logic [1:0]
  {
    DCC_AM_NONPAGE = 2'h0,
    DCC_AM_BURST = 2'h1,
    DCC_AM_CONT = 2'h2,
    DCC_AM_EDO = 2'h3
  } dcc_amode_t;

  typedef enum logic [2:0]
  {
    DCC_ST_IDLE = 3'h0,
    DCC_ST_ROW = 3'h1,
    DCC_ST_COL = 3'h2,
    DCC_ST_PAGE = 3'h3,
    DCC_ST_PRE = 3'h4,
    DCC_ST_REF = 3'h5
  } dcc_state_t;

endpackage : dcc_pkg

// ===== rtl/dcc_refresh.sv
`timescale 1ns/1ps
`default_nettype none

module dcc_refresh
  import dcc_pkg::*;
#(
  parameter int RC_UNIT = DCC_RC_UNIT
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [DCC_RC_W-1:0] refresh_count,
  input wire logic ref_ack,
  output logic ref_req
);

  // The longest reload must still fit the interval counter.
  if (RC_UNIT < 1 || RC_UNIT * (2 ** DCC_RC_W) >= 2 ** DCC_RC_CNT_W)
  begin : g_bad_unit
    $error("dcc_refresh: RC_UNIT cannot be served");
  end

  localparam logic [DCC_RC_CNT_W-1:0] UNIT_CNT =
    DCC_RC_CNT_W'(RC_UNIT);

  logic [DCC_RC_CNT_W-1:0] interval_ff;
  logic [DCC_RC_CNT_W-1:0] nxt_interval;
  logic req_ff;
  logic [DCC_RC_CNT_W-1:0] reload;

  // One refresh count of zero still gives one unit, so refresh never stops.
  assign reload = DCC_RC_CNT_W'((refresh_count + 1'b1) * UNIT_CNT);
  assign nxt_interval = ref_ack ? reload :
                        (interval_ff != '0) ? interval_ff - 1'b1 :
                        interval_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      interval_ff <= UNIT_CNT;
      req_ff <= 1'b0;
    end
    else
    begin
      interval_ff <= nxt_interval;
      // Request set wins over acknowledge arriving in the same cycle.
      req_ff <= (interval_ff == 1) | (req_ff & ~ref_ack);
    end
  end

  assign ref_req = req_ff;

endmodule : dcc_refresh

`default_nettype wire

// ===== bench/dcc_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module dcc_ctrl_monitor
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic mem_req,
  input wire logic mem_ack,
  input wire logic mem_miss,
  input wire logic [1:0] row_strobe_n,
  input wire logic sync_row_strobe_n
);
  default clocking mon_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Block 0 opening alone, so a refresh of both blocks is excluded.
  sequence block0_opened;
    mem_req && $fell(row_strobe_n[0]) && row_strobe_n[1];
  endsequence

  AST_WRITE_ANSWER: assert property (write_taken |=> s_axi_bvalid)
    else $error("write response missing");
  AST_B_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write accepted while response pending");
  AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing");
  AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  AST_ACK_CAUSE: assert property (mem_ack |-> !mem_miss && $past(mem_req))
    else $error("memory ack without request");
  AST_MISS_IDLE: assert property (mem_miss |-> row_strobe_n == 2'b11)
    else $error("miss reported with a row open");
  AST_ACK_PULSE: assert property (mem_ack |=> !mem_ack)
    else $error("memory ack longer than one cycle");
  AST_ROW_SERVICE: assert property (block0_opened |-> ##[1:30] mem_ack)
    else $error("opened row not completed");
  AST_SYNC_PIN: assert property (!sync_row_strobe_n |-> !(&row_strobe_n))
    else $error("sync strobe low with no row open");
endmodule : dcc_ctrl_monitor

bind dcc_ctrl dcc_ctrl_monitor i_monitor (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .mem_req(mem_req), .mem_ack(mem_ack),
  .mem_miss(mem_miss), .row_strobe_n(row_strobe_n),
  .sync_row_strobe_n(sync_row_strobe_n));

`default_nettype wire

// ===== bench/dcc_dram_model.sv
`timescale 1ns/1ps
`default_nettype none

module dcc_dram_model
(
  input wire logic aclk,
  input wire logic clr,
  input wire logic [1:0] row_strobe_n,
  input wire logic [3:0] column_strobe_n,
  input wire logic dram_write,
  input wire logic sync_row_strobe_n,
  input wire logic sync_column_strobe_n,
  input wire logic [11:0] dram_addr,
  output logic [11:0] row_addr_seen,
  output logic [11:0] col_addr_seen,
  output logic [1:0] rows_seen,
  output logic [3:0] lanes_seen,
  output logic wr_seen,
  output logic sync_seen,
  output logic [7:0] ref_cnt
);
  logic [1:0] row_q;

  // Lanes are only gathered outside refresh, which drives every strobe.
  always_ff @(posedge aclk)
  begin
    row_q <= row_strobe_n;
    if (clr)
    begin
      rows_seen <= 2'h0;
      lanes_seen <= 4'h0;
      wr_seen <= 1'b0;
      sync_seen <= 1'b0;
      ref_cnt <= 8'h00;
      row_addr_seen <= 12'h000;
      col_addr_seen <= 12'h000;
    end
    else
    begin
      if (row_strobe_n == 2'b00 && row_q != 2'b00)
        ref_cnt <= ref_cnt + 8'h01;
      if (^row_strobe_n)
        rows_seen <= rows_seen | ~row_strobe_n;
      if (row_strobe_n != 2'b00)
        lanes_seen <= lanes_seen | ~column_strobe_n;
      if (^row_strobe_n && row_q == 2'b11)
        row_addr_seen <= dram_addr;
      if (^row_strobe_n && column_strobe_n != 4'hF)
        col_addr_seen <= dram_addr;
      wr_seen <= wr_seen | dram_write;
      sync_seen <= sync_seen | (~sync_row_strobe_n & ~sync_column_strobe_n);
    end
  end
endmodule : dcc_dram_model

`default_nettype wire

// ===== bench/dcc_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none

module dcc_ctrl_test;
  import dcc_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, mem_req, mem_write, mem_ack;
  logic mem_miss, dram_write, clr, wr_seen, sync_seen;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, mem_addr;
  logic [3:0] wstrb, col_n, lanes;
  logic [1:0] bresp, rresp, row_n, rows;
  logic [7:0] refs;
  logic sync_row_n, sync_col_n;
  logic [11:0] dram_a, row_a, col_a;
  int err_count, check_count, c1, c2;
  logic h;

  dcc_ctrl #(.RC_UNIT(1)) i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_write(mem_write), .mem_ack(mem_ack),
    .mem_miss(mem_miss), .row_strobe_n(row_n), .column_strobe_n(col_n),
    .dram_write(dram_write), .dram_addr(dram_a),
    .sync_row_strobe_n(sync_row_n), .sync_column_strobe_n(sync_col_n));
  dcc_dram_model i_dram (.aclk(aclk), .clr(clr), .row_strobe_n(row_n),
    .column_strobe_n(col_n), .dram_write(dram_write),
    .sync_row_strobe_n(sync_row_n), .sync_column_strobe_n(sync_col_n),
    .dram_addr(dram_a), .row_addr_seen(row_a), .col_addr_seen(col_a),
    .rows_seen(rows),
    .lanes_seen(lanes), .wr_seen(wr_seen), .sync_seen(sync_seen),
    .ref_cnt(refs));

  always #4 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////
  task stop_test();
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task tmo();
    err_count++;
    $display("unexpected at %0t: wait ran out", $time);
    stop_test();
  endtask : tmo

  task rst();
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask : rst

  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic [1:0] r;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      r = bresp;
      if (n > 100) tmo();
    end
    while (!bvalid);
    bready <= 1'b0;
    chk({30'h0, r}, {30'h0, er});
    @(posedge aclk);
  endtask : wr

  task rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (n > 100) tmo();
    end
    while (!rvalid);
    rready <= 1'b0;
    chk(rdata, ed);
    chk({30'h0, rresp}, {30'h0, er});
    @(posedge aclk);
  endtask : rd

  // Refresh has priority, so the bound covers a refresh plus an access.
  task mem(input logic [31:0] a, input logic w, output int cyc);
    mem_addr <= a;
    mem_write <= w;
    mem_req <= 1'b1;
    cyc = 0;
    do
    begin
      @(posedge aclk);
      cyc++;
      if (cyc > 300) tmo();
    end
    while (!(mem_ack || mem_miss));
    h = mem_ack;
    mem_req <= 1'b0;
    @(posedge aclk);
  endtask : mem

  task clear_model();
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    @(posedge aclk);
  endtask : clear_model

  ////////////////////////////////////////////////////////////////////////
  task t_reset_values();
    rd(DCC_CTRL_OFF, DCC_CTRL_RESET, DCC_RESP_OKAY);
    rd(DCC_BLK0_ADDR_OFF, DCC_BLK_ADDR_RESET, DCC_RESP_OKAY);
    rd(DCC_BLK1_MASK_OFF, DCC_BLK_MASK_RESET, DCC_RESP_OKAY);
    rd(12'h104, 32'h0000_0000, DCC_RESP_SLVERR);
    wr(12'h104, 32'hFFFF_FFFF, DCC_RESP_SLVERR);
  endtask : t_reset_values

  task t_blocks();
    wr(DCC_CTRL_OFF, 32'h0000_00FF, DCC_RESP_OKAY);
    wr(DCC_BLK0_ADDR_OFF, 32'h0000_0001, DCC_RESP_OKAY);
    wr(DCC_BLK1_ADDR_OFF, 32'h0004_0001, DCC_RESP_OKAY);
    rd(DCC_BLK0_ADDR_OFF, 32'h0000_0001, DCC_RESP_OKAY);
    rd(DCC_BLK1_ADDR_OFF, 32'h0004_0001, DCC_RESP_OKAY);
    clear_model();
    mem(32'h0000_0100, 1'b0, c1);
    chk({31'h0, h}, 32'h1);
    mem(32'h0004_0100, 1'b1, c1);
    chk({31'h0, h}, 32'h1);
    mem(32'h8000_0000, 1'b0, c1);
    chk({31'h0, h}, 32'h0);
    chk({30'h0, rows}, 32'h3);
    chk({31'h0, wr_seen}, 32'h1);
    chk({20'h0, row_a}, 32'h0000_0200);
    chk({20'h0, col_a}, 32'h0000_0100);
  endtask : t_blocks

  task t_sizes();
    logic [3:0] exp_lanes [3];
    exp_lanes = '{4'hF, 4'h1, 4'h3};
    for (int ps = 0; ps < 3; ps++)
    begin
      wr(DCC_BLK0_ADDR_OFF, (ps << DCC_PS_LSB) | 1, DCC_RESP_OKAY);
      clear_model();
      mem(32'h0000_0200, 1'b1, c1);
      chk({28'h0, lanes}, {28'h0, exp_lanes[ps]});
    end
  endtask : t_sizes

  // Only the non-page mode closes the row, so a repeat is no faster there.
  task t_modes();
    int n;
    clear_model();
    n = 0;
    while (refs == 8'h00)
    begin
      @(posedge aclk);
      n++;
      if (n > 300) tmo();
    end
    // Start just after a refresh so that none lands inside a timed pair.
    repeat (8) @(posedge aclk);
    for (int m = 0; m < 4; m++)
    begin
      wr(DCC_BLK0_ADDR_OFF, (m << DCC_MODE_LSB) | 1, DCC_RESP_OKAY);
      // A fresh row each pass, so a row left open by the last mode misses.
      mem(32'h0000_0100 + (m << 12), 1'b0, c1);
      mem(32'h0000_0104 + (m << 12), 1'b0, c2);
      chk({31'h0, h}, 32'h1);
      chk({31'h0, c2 < c1}, {31'h0, m != 0});
    end
    wr(DCC_BLK0_ADDR_OFF, 32'h0000_0001, DCC_RESP_OKAY);
  endtask : t_modes

  task t_refresh();
    clear_model();
    repeat (600) @(posedge aclk);
    mem(32'h0004_0000, 1'b0, c1);
    chk({31'h0, h}, 32'h1);
    repeat (700 - c1) @(posedge aclk);
    chk({31'h0, refs >= 8'h04 && refs <= 8'h06}, 32'h1);
  endtask : t_refresh

  task t_sync();
    wr(DCC_CTRL_OFF, 32'h0000_80FF, DCC_RESP_OKAY);
    wr(DCC_CTRL_OFF, 32'h0000_00FF, DCC_RESP_OKAY);
    rd(DCC_CTRL_OFF, 32'h0000_80FF, DCC_RESP_OKAY);
    clear_model();
    mem(32'h0004_0100, 1'b0, c1);
    chk({31'h0, sync_seen}, 32'h1);
    rst();
    rd(DCC_CTRL_OFF, DCC_CTRL_RESET, DCC_RESP_OKAY);
    wr(DCC_CTRL_OFF, 32'h0000_00FF, DCC_RESP_OKAY);
    clear_model();
    mem(32'h0000_0100, 1'b0, c1);
    chk({31'h0, h}, 32'h0);
    chk({31'h0, sync_seen}, 32'h0);
  endtask : t_sync

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, mem_req, mem_write} = 7'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    mem_addr = 32'h0000_0000;
    clr = 1'b1;
    err_count = 0;
    check_count = 0;
    rst();
    t_reset_values();
    t_blocks();
    t_sizes();
    t_modes();
    t_refresh();
    t_sync();
    stop_test();
  end
endmodule : dcc_ctrl_test

`default_nettype wire
